/* rtl/pco_clock_out.sv */
// clock output control with 16-bit timer count clock select
`timescale 1ns/10ps
module pco_clock_out (
  input wire logic clk,
  input wire logic rstn,
  input pco_pkg::pco_req_t req,
  output logic [7:0] rdata,
  input wire logic divider_bypass_bit,
  input wire logic port3_bit5_latch,
  input wire logic sub_clk_in,
  input wire logic external_timer_input,
  input wire logic watch_timer_tick,
  output pco_pkg::pco_pin_t port3_bit5_pin,
  output logic timer_count_clk
);
  import pco_pkg::*;

  ////////////////////////////////////////////////////////////////
  // tap of a free-running divider; clk is twice the oscillator
  function automatic logic tap(input logic [DIV_W-1:0] cnt, input logic [3:0] idx,
                               input logic bypass);
    logic [3:0] pos;
    pos = idx - {3'h0, bypass};
    if (idx == 4'h0 && bypass)
      tap = 1'b0;
    else
      tap = cnt[pos];
  endfunction : tap

  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] sub_sync_r;
  logic [1:0] ti_sync_r;
  logic [1:0] sub_sync_nxt;
  logic [1:0] ti_sync_nxt;

  always_comb begin
    sub_sync_nxt = {sub_sync_r[0], sub_clk_in};
    ti_sync_nxt = {ti_sync_r[0], external_timer_input};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sub_sync_r <= 2'b00;
      ti_sync_r <= 2'b00;
    end else begin
      sub_sync_r <= sub_sync_nxt;
      ti_sync_r <= ti_sync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] sel_r;
  logic [7:0] sel_nxt;
  logic [7:0] dir_r;
  logic [7:0] dir_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  always_comb begin
    sel_nxt = sel_r;
    dir_nxt = dir_r;
    rdata_nxt = 8'h00;
    if (req.addr == SEL_ADDR) begin
      if (req.wr)
        sel_nxt = req.wdata;
      else if (req.bit_wr)
        sel_nxt[req.bit_sel] = req.bit_val;
      if (req.rd)
        rdata_nxt = sel_r;
    end
    if (req.addr == PORT3_DIR_ADDR) begin
      if (req.wr)
        dir_nxt = req.wdata;
      else if (req.bit_wr)
        dir_nxt[req.bit_sel] = req.bit_val;
      if (req.rd)
        rdata_nxt = dir_r;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_r <= SEL_RESET;
      dir_r <= PORT3_DIR_RESET;
      rdata_r <= 8'h00;
    end else begin
      sel_r <= sel_nxt;
      dir_r <= dir_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // divider and source selection
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic out_wave;
  logic tmr_wave;
  logic [3:0] osrc;
  logic [2:0] tsrc;

  always_comb begin
    div_nxt = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    osrc = sel_r[OSRC_HI:OSRC_LO];
    tsrc = sel_r[TSRC_HI:TSRC_LO];
    out_wave = 1'b0;
    if (osrc == OSRC_SUB)
      out_wave = sub_sync_r[1];
    else if (osrc >= OSRC_DIV1 && osrc <= OSRC_DIV128)
      out_wave = tap(div_r, osrc - OSRC_DIV1 + TAP_FXX, divider_bypass_bit);
    tmr_wave = 1'b0;
    if (tsrc == TSRC_EXT)
      tmr_wave = ti_sync_r[1];
    else if (tsrc >= TSRC_DBL && tsrc <= TSRC_DIV4)
      tmr_wave = tap(div_r, {1'b0, tsrc - TSRC_DBL}, divider_bypass_bit);
    else if (tsrc == TSRC_WATCH)
      tmr_wave = watch_timer_tick;
  end

  ////////////////////////////////////////////////////////////////
  // glitch-free gate and pin drive
  pco_gate_t gate_r;
  pco_gate_t gate_nxt;
  pco_pin_t pin_r;
  pco_pin_t pin_nxt;
  logic tmr_r;

  always_comb begin
    gate_nxt = gate_r;
    // gate only moves while the source is low
    if (!out_wave) begin
      case (gate_r)
        GATE_OFF: gate_nxt = sel_r[ENABLE_BIT] ? GATE_ON : GATE_OFF;
        GATE_ON: gate_nxt = sel_r[ENABLE_BIT] ? GATE_ON : GATE_OFF;
        default: gate_nxt = GATE_OFF;
      endcase
    end
    pin_nxt.oe = ~dir_r[PIN_DIR_BIT];
    if (port3_bit5_latch)
      pin_nxt.o = 1'b1;
    else
      pin_nxt.o = (gate_nxt == GATE_ON) & out_wave;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= '0;
      gate_r <= GATE_OFF;
      pin_r <= '0;
      tmr_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      gate_r <= gate_nxt;
      pin_r <= pin_nxt;
      tmr_r <= tmr_wave;
    end
  end

  assign rdata = rdata_r;
  assign port3_bit5_pin = pin_r;
  assign timer_count_clk = tmr_r;
endmodule : pco_clock_out

/* rtl/pco_pkg.sv */
// constants and carrier types of the programmable clock output block
package pco_pkg;
  localparam logic [15:0] SEL_ADDR = 16'hFF40;
  localparam logic [15:0] PORT3_DIR_ADDR = 16'hFF23;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [7:0] PORT3_DIR_RESET = 8'hFF;
  localparam int ENABLE_BIT = 7;
  localparam int TSRC_HI = 6;
  localparam int TSRC_LO = 4;
  localparam int OSRC_HI = 3;
  localparam int OSRC_LO = 0;
  localparam int PIN_DIR_BIT = 5;
  localparam int DIV_W = 9;
  // out_source_field codes
  localparam logic [3:0] OSRC_SUB = 4'h0;
  localparam logic [3:0] OSRC_DIV1 = 4'h5;
  localparam logic [3:0] OSRC_DIV128 = 4'hC;
  // timer source codes
  localparam logic [2:0] TSRC_EXT = 3'h0;
  localparam logic [2:0] TSRC_DBL = 3'h1;
  localparam logic [2:0] TSRC_DIV4 = 3'h4;
  localparam logic [2:0] TSRC_WATCH = 3'h7;
  // tap index of fxx/1 relative to a doubled fxx
  localparam logic [3:0] TAP_FXX = 4'h1;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
    logic [7:0] wdata;
  } pco_req_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pco_pin_t;

  typedef enum logic {GATE_OFF, GATE_ON} pco_gate_t;
endpackage : pco_pkg

/* test/pco_clock_out_chk.sv */
// assertions on the ports of the clock output block
`timescale 1ns/10ps
module pco_clock_out_chk (
  input wire logic clk,
  input wire logic rstn,
  input pco_pkg::pco_req_t req,
  input wire logic [7:0] rdata,
  input wire logic divider_bypass_bit,
  input wire logic port3_bit5_latch,
  input wire logic external_timer_input,
  input pco_pkg::pco_pin_t port3_bit5_pin,
  input wire logic timer_count_clk
);
  import pco_pkg::*;
  logic [7:0] sel_r;
  wire logic o = port3_bit5_pin.o;
  wire logic lt = port3_bit5_latch;
  wire logic byp = divider_bypass_bit;
  wire logic ext = external_timer_input;
  // shadow of the select register
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) sel_r <= SEL_RESET;
    else if (req.wr && req.addr == SEL_ADDR) sel_r <= req.wdata;
    else if (req.bit_wr && req.addr == SEL_ADDR) sel_r[req.bit_sel] <= req.bit_val;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_l; lt |=> o; endproperty
  a_l: assert property (p_l) else $error("latch");
  property p_r; $rose(o) |-> $past(sel_r[7], 2) || $past(lt); endproperty
  a_r: assert property (p_r) else $error("rise");
  property p_x; (sel_r[6:4] == TSRC_EXT && $stable(ext))[*5] |-> timer_count_clk == ext; endproperty
  a_x: assert property (p_x) else $error("timer");
  property p_n; (!(sel_r[3:0] inside {4'h0, [4'h5:4'hC]}) && !lt)[*3] |-> !o; endproperty
  a_n: assert property (p_n) else $error("code");
  property p_b1; (sel_r == 8'h85 && byp && !lt)[*6] |-> o != $past(o); endproperty
  a_b1: assert property (p_b1) else $error("fx");
  property p_b0; (sel_r == 8'h85 && !byp && !lt)[*6] |-> o != $past(o, 2); endproperty
  a_b0: assert property (p_b0) else $error("fx2");
  property p_rd; req.rd && req.addr == SEL_ADDR |=> rdata == $past(sel_r); endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_z; !req.rd |=> rdata == 8'h00; endproperty
  a_z: assert property (p_z) else $error("idle");
endmodule : pco_clock_out_chk
bind pco_clock_out pco_clock_out_chk chk (.*);

/* test/pco_sink.sv */
// clock receiver: counts high pulses and keeps the shortest
`timescale 1ns/10ps
module pco_sink (
  input wire logic clk,
  input pco_pkg::pco_pin_t pin,
  output int pulses,
  output int min_hi
);
  import pco_pkg::*;
  int hi = 0;
  initial pulses = 0;
  initial min_hi = 9999;
  always @(posedge clk) begin
    if (pin.oe && pin.o) hi++;
    else if (hi > 0) begin
      if (hi < min_hi) min_hi = hi;
      pulses++;
      hi = 0;
    end
  end
endmodule : pco_sink

/* test/programmable_clock_output_tb.sv */
// testbench of the clock output block
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module programmable_clock_output_tb;
  import pco_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  pco_req_t req = '0;
  logic [7:0] rdata;
  logic byp = 0;
  logic lt = 0;
  logic [7:0] cyc = 8'h00;
  pco_pin_t pin;
  logic tcc;
  logic [7:0] sel_m = SEL_RESET;
  logic [7:0] dir_m = PORT3_DIR_RESET;
  int n_fail = 0;
  int checks_done = 0;
  int pulses, min_hi, e0, k, n;
  pco_clock_out uut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
    .divider_bypass_bit(byp), .port3_bit5_latch(lt), .sub_clk_in(cyc[6]),
    .external_timer_input(cyc[3]), .watch_timer_tick(cyc[2]), .port3_bit5_pin(pin),
    .timer_count_clk(tcc));
  pco_sink sink (.clk(clk), .pin(pin), .pulses(pulses), .min_hi(min_hi));
  initial forever #50 clk = ~clk;
  always @(negedge clk) cyc <= cyc + 8'h01;
  // kd: 0 read, 1 byte write, 2 bit write (d[2:0] bit, d[3] value)
  task automatic op(input int kd, input logic [15:0] a, input logic [7:0] d);
    pco_req_t r;
    logic [7:0] ex;
    r = '0;
    r.addr = a;
    r.rd = kd == 0;
    r.wr = kd == 1;
    r.bit_wr = kd == 2;
    r.wdata = d;
    r.bit_sel = d[2:0];
    r.bit_val = d[3];
    ex = a == SEL_ADDR ? sel_m : a == PORT3_DIR_ADDR ? dir_m : 8'h00;
    if (kd == 1) ex = d;
    if (kd == 2) ex[d[2:0]] = d[3];
    if (a == SEL_ADDR) sel_m = ex;
    if (a == PORT3_DIR_ADDR) dir_m = ex;
    @(negedge clk);
    req = r;
    @(negedge clk);
    req = '0;
    if (kd == 0) `CHK(rdata, ex)
  endtask : op
  task automatic summarize();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    summarize();
  end
  initial begin
    e0 = $urandom(32'h36623D79);
    repeat (6) @(negedge clk);
    rstn = 1;
    op(0, SEL_ADDR, 8'h00);
    op(0, PORT3_DIR_ADDR, 8'h00);
    op(0, 16'hFF41, 8'h00);
    repeat (6) begin
      op(1, SEL_ADDR, 8'h7F & 8'($urandom));
      op(2, SEL_ADDR, 8'($urandom));
      op(0, SEL_ADDR, 8'h00);
    end
    op(2, SEL_ADDR, 8'h07);
    repeat (300) @(negedge clk);
    op(1, PORT3_DIR_ADDR, 8'hDF);
    for (int i = 0; i < 16; i++) begin
      k = 12 - i / 2;
      byp = i[0];
      n = k - 5 + !byp;
      op(1, SEL_ADDR, 8'(k));
      e0 = pulses;
      op(2, SEL_ADDR, 8'h0F);
      repeat (8 << n) @(negedge clk);
      op(2, SEL_ADDR, 8'h07);
      repeat (4 << n) @(negedge clk);
      `CHK(min_hi, 1 << n)
      `CHK(pulses > e0, 1'b1)
      `CHK(pin.o, 1'b0)
    end
    op(1, SEL_ADDR, 8'h70);
    repeat (4) begin
      @(negedge clk);
      `CHK(tcc, cyc[2])
    end
    op(1, SEL_ADDR, 8'h20);
    @(negedge clk);
    repeat (4) begin
      e0 = tcc;
      @(negedge clk);
      `CHK(tcc, ~e0[0])
    end
    lt = 1;
    repeat (4) @(negedge clk);
    lt = 0;
    summarize();
  end
endmodule : programmable_clock_output_tb
